// *** verilog/cpsb_pkg.sv ***
// Package for the CPU status word and bank addressing block
package cpsb_pkg;

  // Status word field positions
  localparam int BANK_HI = 15;
  localparam int BANK_LO = 11;
  localparam int WIN_HI = 10;
  localparam int WIN_LO = 8;
  localparam int FLAG_HALF = 7;
  localparam int FLAG_ALLOW = 4;
  localparam int FLAG_LVL_HI = 6;
  localparam int FLAG_LVL_LO = 5;
  localparam int FLAG_MSB = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVF = 1;
  localparam int FLAG_CARRY = 0;

  // Mirror address, reset values and address map constants
  localparam logic [15:0] MIRROR_ADDR = 16'h0078;
  localparam logic [15:0] PSW_RESET = 16'h0060;
  localparam logic [1:0] LEVEL_NONE = 2'h3;
  localparam logic [15:0] BANK_BASE = 16'h0100;
  localparam logic [15:0] DIRECT_LOW_MAX = 16'h007f;
  localparam logic [15:0] WINDOW_BASE = 16'h0080;

  // Flag update sources
  typedef enum logic [1:0] {
    CPSB_OP_NONE = 2'b00,
    CPSB_OP_ARITH = 2'b01,
    CPSB_OP_XFER = 2'b10,
    CPSB_OP_SHIFT = 2'b11
  } cpsb_op_e;

  // Operation result bundle from execution
  typedef struct packed {
    cpsb_op_e kind;
    logic word;
    logic [15:0] result;
    logic half_carry;
    logic carry;
    logic overflow;
    logic shift_out;
  } cpsb_res_s;

  // Status write requests
  typedef struct packed {
    logic psw_we;
    logic [15:0] psw_data;
    logic mirror_we;
    logic [7:0] mirror_data;
    logic mask_open;
    logic mask_close;
    logic level_we;
    logic [1:0] level_data;
  } cpsb_wr_s;

endpackage

// *** verilog/cpsb_addr_map.sv ***
// Address mapping for bank registers and direct operands
`timescale 1ns/1ps
module cpsb_addr_map
  import cpsb_pkg::*;
(
  // Pointer fields
  input wire logic [4:0] bank_select,
  input wire logic [2:0] direct_window,
  // Operands
  input wire logic [7:0] opcode,
  input wire logic [7:0] direct_operand,
  // Mapped addresses
  output logic [15:0] bank_reg_addr,
  output logic [15:0] direct_addr
);
  assign bank_reg_addr = BANK_BASE + {5'h00, bank_select, opcode[2:0]};

  always_comb begin
    if ({8'h00, direct_operand} <= DIRECT_LOW_MAX) begin
      direct_addr = {8'h00, direct_operand};
    end else begin
      direct_addr = WINDOW_BASE + {6'h00, direct_window, direct_operand[6:0]};
    end
  end
endmodule

// *** verilog/cpsb_word_order.sv ***
// Big-endian byte placement for 16-bit data
`timescale 1ns/1ps
module cpsb_word_order (
  // Inputs: word to split and bytes to join
  input wire logic [15:0] word_in,
  input wire logic [7:0] byte_low_addr,
  input wire logic [7:0] byte_next_addr,
  // Outputs: split bytes and joined word
  output logic [7:0] out_low_addr,
  output logic [7:0] out_next_addr,
  output logic [15:0] word_out
);
  assign out_low_addr = word_in[15:8];
  assign out_next_addr = word_in[7:0];
  assign word_out = {byte_low_addr, byte_next_addr};
endmodule

// *** verilog/cpsb_status.sv ***
// Program status word, flags, interrupt gating and addressing
`timescale 1ns/1ps
module cpsb_status
  import cpsb_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Execution results
  input wire cpsb_res_s RES,
  // Status writes
  input wire cpsb_wr_s WR,
  // Bus byte access
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_RD,
  output logic [7:0] MIRROR_RDATA,
  output logic MIRROR_HIT,
  // Word move read
  output logic [15:0] PSW,
  // Addressing
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] DIRECT_OPERAND,
  output logic [15:0] BANK_REG_ADDR,
  output logic [15:0] DIRECT_ADDR,
  // Interrupt request
  input wire logic IRQ_VALID,
  input wire logic [1:0] IRQ_LEVEL,
  output logic IRQ_ACCEPT,
  // Stack push of a word
  input wire logic [15:0] PUSH_WORD,
  output logic [7:0] PUSH_LOW_ADDR_BYTE,
  output logic [7:0] PUSH_NEXT_ADDR_BYTE,
  // Operand bytes from instruction stream
  input wire logic [7:0] OPND_NEAR,
  input wire logic [7:0] OPND_FAR,
  output logic [15:0] OPND_WORD
);

  logic [4:0] bank_select;
  logic [2:0] direct_window;
  logic [7:0] condition_flags;
  logic [7:0] next_flags;
  logic [15:0] res_eff;
  logic res_msb;
  logic allow_request;
  logic [1:0] current_level;

  assign allow_request = condition_flags[FLAG_ALLOW];
  assign current_level = {condition_flags[FLAG_LVL_HI],
                          condition_flags[FLAG_LVL_LO]};

  assign PSW = {bank_select, direct_window, condition_flags};

  // Pointer fields: word move and mirror share ownership
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bank_select <= PSW_RESET[BANK_HI:BANK_LO];
      direct_window <= PSW_RESET[WIN_HI:WIN_LO];
    end else if (WR.psw_we) begin
      bank_select <= WR.psw_data[BANK_HI:BANK_LO];
      direct_window <= WR.psw_data[WIN_HI:WIN_LO];
    end else if (WR.mirror_we) begin
      bank_select <= WR.mirror_data[7:3];
      direct_window <= WR.mirror_data[2:0];
    end
  end

  assign MIRROR_HIT = BUS_RD && (BUS_ADDR == MIRROR_ADDR);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MIRROR_RDATA <= 8'h00;
    end else if (MIRROR_HIT) begin
      MIRROR_RDATA <= {bank_select, direct_window};
    end
  end

  // Byte results only look at the low byte
  assign res_eff = RES.word ? RES.result : {8'h00, RES.result[7:0]};
  assign res_msb = RES.word ? RES.result[15] : RES.result[7];

  always_comb begin
    next_flags = condition_flags;
    if (RES.kind != CPSB_OP_NONE) begin
      next_flags[FLAG_MSB] = res_msb;
      next_flags[FLAG_ZERO] = (res_eff == 16'h0000);
    end
    if (RES.kind == CPSB_OP_ARITH) begin
      next_flags[FLAG_HALF] = RES.half_carry;
      next_flags[FLAG_OVF] = RES.overflow;
      next_flags[FLAG_CARRY] = RES.carry;
    end
    if (RES.kind == CPSB_OP_SHIFT) begin
      next_flags[FLAG_CARRY] = RES.shift_out;
    end
    if (WR.mask_open) begin
      next_flags[FLAG_ALLOW] = 1'b1;
    end else if (WR.mask_close) begin
      next_flags[FLAG_ALLOW] = 1'b0;
    end
    if (WR.level_we) begin
      next_flags[FLAG_LVL_HI] = WR.level_data[1];
      next_flags[FLAG_LVL_LO] = WR.level_data[0];
    end
  end

  // Flags take the low byte of the word on a word move, otherwise the computed next flags
  always_ff @(posedge CLK) begin
    if (RESET) begin
      condition_flags <= PSW_RESET[7:0];
    end else if (WR.psw_we) begin
      condition_flags <= WR.psw_data[7:0];
    end else begin
      condition_flags <= next_flags;
    end
  end

  assign IRQ_ACCEPT = IRQ_VALID && allow_request &&
                      (IRQ_LEVEL < current_level);

  cpsb_addr_map u_map (
    .bank_select(bank_select),
    .direct_window(direct_window),
    .opcode(OPCODE),
    .direct_operand(DIRECT_OPERAND),
    .bank_reg_addr(BANK_REG_ADDR),
    .direct_addr(DIRECT_ADDR)
  );

  cpsb_word_order u_order (
    .word_in(PUSH_WORD),
    .byte_low_addr(OPND_NEAR),
    .byte_next_addr(OPND_FAR),
    .out_low_addr(PUSH_LOW_ADDR_BYTE),
    .out_next_addr(PUSH_NEXT_ADDR_BYTE),
    .word_out(OPND_WORD)
  );

  // Checks
  a_bank_reset: assert property (@(posedge CLK)
    RESET |=> PSW[15:11] == 5'h00) else $error("bank not cleared");
  a_window_reset: assert property (@(posedge CLK)
    RESET |=> PSW[10:8] == 3'h0) else $error("window not cleared");
  a_level_reset: assert property (@(posedge CLK)
    RESET |=> current_level == LEVEL_NONE && !allow_request)
    else $error("level reset wrong");
  a_irq_gate: assert property (@(posedge CLK) disable iff (RESET)
    IRQ_ACCEPT |-> allow_request && IRQ_LEVEL < current_level)
    else $error("bad accept");
  a_mirror_write: assert property (@(posedge CLK) disable iff (RESET)
    WR.mirror_we && !WR.psw_we |=> PSW[15:8] == $past(WR.mirror_data) &&
    PSW[7:0] == $past(next_flags)) else $error("mirror write wrong");
  a_zero_flag: assert property (@(posedge CLK) disable iff (RESET)
    RES.kind != CPSB_OP_NONE && !WR.psw_we && !WR.level_we |=>
    PSW[FLAG_ZERO] == ($past(res_eff) == 16'h0000))
    else $error("zero flag wrong");
  a_msb_flag: assert property (@(posedge CLK) disable iff (RESET)
    RES.kind != CPSB_OP_NONE && !WR.psw_we |=> PSW[FLAG_MSB] == $past(res_msb))
    else $error("msb flag wrong");
  a_shift_carry: assert property (@(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_SHIFT && !WR.psw_we |=>
    PSW[FLAG_CARRY] == $past(RES.shift_out)) else $error("shift carry wrong");
  a_psw_write: assert property (@(posedge CLK) disable iff (RESET)
    WR.psw_we |=> PSW == $past(WR.psw_data)) else $error("word move wrong");
  a_bank_addr: assert property (@(posedge CLK) disable iff (RESET)
    BANK_REG_ADDR[15:8] == 8'h01) else $error("bank address out");
  a_low_direct: assert property (@(posedge CLK) disable iff (RESET)
    !DIRECT_OPERAND[7] |-> DIRECT_ADDR == {8'h00, DIRECT_OPERAND})
    else $error("low direct moved");

  // Flag checks skip word move cycles, since the move wins
  a_half_carry: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_ARITH && !WR.psw_we |=>
    PSW[FLAG_HALF] == $past(RES.half_carry))
    else $error("half carry wrong");

  a_xfer_half: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_XFER && !WR.psw_we |=>
    PSW[FLAG_HALF] == $past(PSW[FLAG_HALF]))
    else $error("half carry moved on transfer");

  a_ovf_flag: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_ARITH && !WR.psw_we |=>
    PSW[FLAG_OVF] == $past(RES.overflow))
    else $error("overflow flag wrong");

  a_arith_carry: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_ARITH && !WR.psw_we |=>
    PSW[FLAG_CARRY] == $past(RES.carry))
    else $error("arith carry wrong");

  a_zero_byte: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind != CPSB_OP_NONE && !RES.word && RES.result[7:0] == 8'h00 &&
    !WR.psw_we |=> PSW[FLAG_ZERO])
    else $error("byte zero missed");

  a_msb_byte: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind != CPSB_OP_NONE && !RES.word && !WR.psw_we |=>
    PSW[FLAG_MSB] == $past(RES.result[7]))
    else $error("byte msb wrong");

  a_flags_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    RES.kind == CPSB_OP_NONE && !WR.psw_we && !WR.mask_open &&
    !WR.mask_close && !WR.level_we |=> $stable(PSW[7:0]))
    else $error("flags changed idle");

  // Interrupt mask and level bits
  a_mask_open: assert property (
    @(posedge CLK) disable iff (RESET)
    WR.mask_open && !WR.psw_we |=> PSW[FLAG_ALLOW])
    else $error("mask not opened");

  a_mask_close: assert property (
    @(posedge CLK) disable iff (RESET)
    WR.mask_close && !WR.mask_open && !WR.psw_we |=> !PSW[FLAG_ALLOW])
    else $error("mask not closed");

  a_allow_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !WR.psw_we && !WR.mask_open && !WR.mask_close |=>
    $stable(PSW[FLAG_ALLOW]))
    else $error("allow bit moved");

  a_level_write: assert property (
    @(posedge CLK) disable iff (RESET)
    WR.level_we && !WR.psw_we |=>
    PSW[FLAG_LVL_HI:FLAG_LVL_LO] == $past(WR.level_data))
    else $error("level not written");

  a_level_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !WR.psw_we && !WR.level_we |=> $stable(PSW[FLAG_LVL_HI:FLAG_LVL_LO]))
    else $error("level moved");

  // Acceptance seen from the outside word, both directions
  a_irq_closed: assert property (
    @(posedge CLK) disable iff (RESET)
    !PSW[FLAG_ALLOW] |-> !IRQ_ACCEPT)
    else $error("accept while masked");

  a_irq_idle: assert property (
    @(posedge CLK) disable iff (RESET)
    !IRQ_VALID |-> !IRQ_ACCEPT)
    else $error("accept without request");

  a_irq_lowest: assert property (
    @(posedge CLK) disable iff (RESET)
    IRQ_LEVEL == LEVEL_NONE |-> !IRQ_ACCEPT)
    else $error("level three accepted");

  a_irq_serve: assert property (
    @(posedge CLK) disable iff (RESET)
    IRQ_VALID && PSW[FLAG_ALLOW] &&
    IRQ_LEVEL < PSW[FLAG_LVL_HI:FLAG_LVL_LO] |-> IRQ_ACCEPT)
    else $error("request not served");

  // Pointer ownership between word move and mirror
  a_psw_wins: assert property (
    @(posedge CLK) disable iff (RESET)
    WR.psw_we && WR.mirror_we |=> PSW[15:8] == $past(WR.psw_data[15:8]))
    else $error("mirror beat word move");

  a_pointer_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !WR.psw_we && !WR.mirror_we |=> $stable(PSW[15:8]))
    else $error("pointers moved");

  a_mirror_read: assert property (
    @(posedge CLK) disable iff (RESET)
    MIRROR_HIT |=> MIRROR_RDATA == $past(PSW[15:8]))
    else $error("mirror read wrong");

  a_mirror_keep: assert property (
    @(posedge CLK) disable iff (RESET)
    !MIRROR_HIT |=> $stable(MIRROR_RDATA))
    else $error("mirror data moved");

  a_mirror_reset: assert property (
    @(posedge CLK)
    RESET |=> MIRROR_RDATA == 8'h00)
    else $error("mirror data not cleared");

  // Address mapping, checked by field rather than by sum
  a_bank_index: assert property (
    @(posedge CLK) disable iff (RESET)
    BANK_REG_ADDR[2:0] == OPCODE[2:0])
    else $error("bank index wrong");

  a_bank_field: assert property (
    @(posedge CLK) disable iff (RESET)
    BANK_REG_ADDR[7:3] == PSW[BANK_HI:BANK_LO])
    else $error("bank field wrong");

  a_high_direct: assert property (
    @(posedge CLK) disable iff (RESET)
    DIRECT_OPERAND[7] |-> DIRECT_ADDR[6:0] == DIRECT_OPERAND[6:0] &&
    DIRECT_ADDR[15:7] == {6'h00, PSW[WIN_HI:WIN_LO]} + 9'h001)
    else $error("window relocation wrong");

  a_low_window: assert property (
    @(posedge CLK) disable iff (RESET)
    DIRECT_OPERAND[7] && PSW[WIN_HI:WIN_LO] == 3'h0 |->
    DIRECT_ADDR == {8'h00, DIRECT_OPERAND})
    else $error("window zero wrong");

  a_top_window: assert property (
    @(posedge CLK) disable iff (RESET)
    DIRECT_OPERAND[7] && PSW[WIN_HI:WIN_LO] == 3'h7 |->
    DIRECT_ADDR[15:7] == 9'h008)
    else $error("window seven wrong");

  a_direct_range: assert property (
    @(posedge CLK) disable iff (RESET)
    DIRECT_ADDR <= 16'h047f)
    else $error("direct address out");

  // Byte order of words
  a_push_order: assert property (
    @(posedge CLK) disable iff (RESET)
    PUSH_LOW_ADDR_BYTE == PUSH_WORD[15:8] &&
    PUSH_NEXT_ADDR_BYTE == PUSH_WORD[7:0])
    else $error("push order wrong");

  a_opnd_order: assert property (
    @(posedge CLK) disable iff (RESET)
    OPND_WORD[15:8] == OPND_NEAR && OPND_WORD[7:0] == OPND_FAR)
    else $error("operand order wrong");

  c_irq: cover property (@(posedge CLK) IRQ_ACCEPT);
  c_mirror: cover property (@(posedge CLK) WR.mirror_we ##1 MIRROR_HIT);
  c_shift: cover property (@(posedge CLK) RES.kind == CPSB_OP_SHIFT);
  c_window: cover property (@(posedge CLK) DIRECT_ADDR[10]);
  c_psw_move: cover property (@(posedge CLK) WR.psw_we && WR.mirror_we);
endmodule

// *** dv/cpsb_status_tb.sv ***
// Self-checking bench for the status word and addressing block
`timescale 1ns/1ps
module cpsb_status_tb
  import cpsb_pkg::*;
();
  logic CLK, RESET, BUS_RD, MIRROR_HIT, IRQ_VALID, IRQ_ACCEPT;
  cpsb_res_s RES, r;
  cpsb_wr_s WR, w;
  logic [15:0] BUS_ADDR, PSW, BANK_REG_ADDR, DIRECT_ADDR, PUSH_WORD;
  logic [15:0] OPND_WORD, exp_psw;
  logic [7:0] MIRROR_RDATA, OPCODE, DIRECT_OPERAND, OPND_NEAR, OPND_FAR;
  logic [7:0] PUSH_LOW_ADDR_BYTE, PUSH_NEXT_ADDR_BYTE;
  logic [1:0] IRQ_LEVEL;
  int bad_count, num_checks;

  cpsb_status cpsb_status_i (.CLK(CLK), .RESET(RESET), .RES(RES), .WR(WR),
    .BUS_ADDR(BUS_ADDR), .BUS_RD(BUS_RD), .MIRROR_RDATA(MIRROR_RDATA),
    .MIRROR_HIT(MIRROR_HIT), .PSW(PSW), .OPCODE(OPCODE),
    .DIRECT_OPERAND(DIRECT_OPERAND), .BANK_REG_ADDR(BANK_REG_ADDR),
    .DIRECT_ADDR(DIRECT_ADDR), .IRQ_VALID(IRQ_VALID),
    .IRQ_LEVEL(IRQ_LEVEL), .IRQ_ACCEPT(IRQ_ACCEPT), .PUSH_WORD(PUSH_WORD),
    .PUSH_LOW_ADDR_BYTE(PUSH_LOW_ADDR_BYTE),
    .PUSH_NEXT_ADDR_BYTE(PUSH_NEXT_ADDR_BYTE), .OPND_NEAR(OPND_NEAR),
    .OPND_FAR(OPND_FAR), .OPND_WORD(OPND_WORD));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic chk1(input logic got, input logic want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, want);
    end
  endtask

  function automatic logic [7:0] new_flags(input cpsb_res_s x,
                                           input logic [7:0] f);
    logic [7:0] n;
    logic [15:0] v;
    n = f;
    // Byte results ignore the upper half, even when it is not zero
    v = x.word ? x.result : {8'h00, x.result[7:0]};
    if (x.kind != CPSB_OP_NONE) begin
      n[FLAG_MSB] = x.word ? v[15] : v[7];
      n[FLAG_ZERO] = (v == 16'h0000);
    end
    if (x.kind == CPSB_OP_ARITH) begin
      n[FLAG_HALF] = x.half_carry;
      n[FLAG_OVF] = x.overflow;
      n[FLAG_CARRY] = x.carry;
    end
    if (x.kind == CPSB_OP_SHIFT)
      n[FLAG_CARRY] = x.shift_out;
    return n;
  endfunction

  function automatic logic [15:0] exp_dir(input logic [2:0] win,
                                          input logic [7:0] op);
    if (op < 8'h80)
      return {8'h00, op};
    return 16'h0080 + {6'h00, win, 7'h00} + {9'h000, op[6:0]};
  endfunction

  // One edge of status traffic, then the whole word against the model
  task automatic drive(input cpsb_wr_s wv, input cpsb_res_s rv);
    WR = wv;
    RES = rv;
    @(posedge CLK);
    #1;
    if (wv.psw_we)
      exp_psw = wv.psw_data;
    else begin
      if (wv.mirror_we)
        exp_psw[15:8] = wv.mirror_data;
      exp_psw[7:0] = new_flags(rv, exp_psw[7:0]);
      if (wv.mask_open)
        exp_psw[FLAG_ALLOW] = 1'b1;
      else if (wv.mask_close)
        exp_psw[FLAG_ALLOW] = 1'b0;
      if (wv.level_we)
        exp_psw[FLAG_LVL_HI:FLAG_LVL_LO] = wv.level_data;
    end
    chk16(PSW, exp_psw);
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    RESET = 1'b1; RES = '0; WR = '0; BUS_ADDR = 16'h0000; BUS_RD = 1'b0;
    OPCODE = 8'h00; DIRECT_OPERAND = 8'h00; IRQ_VALID = 1'b0;
    IRQ_LEVEL = 2'h0; PUSH_WORD = 16'h0000; OPND_NEAR = 8'h00;
    OPND_FAR = 8'h00;
    void'($urandom(32'h87ca3f7f));
    repeat (16) @(posedge CLK);
    #1;
    RESET = 1'b0;
    exp_psw = 16'h0060;
    chk16(PSW, 16'h0060);
    chk16({8'h00, MIRROR_RDATA}, 16'h0000);
    w = '0;
    w.mirror_we = 1'b1;
    w.mirror_data = 8'h19;
    drive(w, '0);
    r = '0;
    r.kind = CPSB_OP_ARITH;
    r.result = 16'hff00;
    r.half_carry = 1'b1;
    r.overflow = 1'b1;
    drive('0, r);
    r.kind = CPSB_OP_XFER;
    r.word = 1'b1;
    r.result = 16'h8000;
    drive('0, r);
    r.kind = CPSB_OP_SHIFT;
    r.shift_out = 1'b1;
    drive('0, r);
    for (int i = 0; i < 200; i++) begin
      w = '0;
      r = cpsb_res_s'(23'($urandom));
      case ($urandom % 4)
        0: begin
          w.psw_we = 1'b1;
          w.psw_data = 16'($urandom);
          w.mirror_we = 1'($urandom);
        end
        1: begin
          w.mirror_we = 1'b1;
          w.mirror_data = 8'($urandom);
        end
        2: begin
          w.mask_open = 1'($urandom);
          w.mask_close = 1'($urandom);
          w.level_we = 1'($urandom);
          w.level_data = 2'($urandom);
        end
        default: ;
      endcase
      drive(w, r);
    end
    IRQ_VALID = 1'b1;
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 4; c++) begin
        w = '0;
        w.mask_open = (a == 1);
        w.mask_close = (a == 0);
        w.level_we = 1'b1;
        w.level_data = 2'(c);
        drive(w, '0);
        for (int l = 0; l < 4; l++) begin
          IRQ_LEVEL = 2'(l);
          #1;
          chk1(IRQ_ACCEPT, (a == 1) && (l < c));
        end
      end
    end
    IRQ_VALID = 1'b0;
    #1;
    chk1(IRQ_ACCEPT, 1'b0);
    for (int i = 0; i < 60; i++) begin
      w = '0;
      w.mirror_we = 1'b1;
      w.mirror_data = (i < 8) ? {5'(i * 4 + 3), 3'(i)} : 8'($urandom);
      drive(w, '0);
      OPCODE = 8'($urandom);
      DIRECT_OPERAND = (i % 4 == 0) ? 8'h7f : (i % 4 == 1) ? 8'h80 :
                       (i % 4 == 2) ? 8'hff : 8'($urandom);
      PUSH_WORD = 16'($urandom);
      OPND_NEAR = 8'($urandom);
      OPND_FAR = 8'($urandom);
      BUS_RD = 1'b1;
      BUS_ADDR = (i % 2 == 1) ? 16'h0078 : 16'h0079;
      #1;
      chk16(BANK_REG_ADDR, 16'h0100 + {8'h00, w.mirror_data[7:3], 3'h0}
            + {13'h0000, OPCODE[2:0]});
      chk16(DIRECT_ADDR, exp_dir(w.mirror_data[2:0], DIRECT_OPERAND));
      chk1(MIRROR_HIT, i % 2 == 1);
      chk16({PUSH_LOW_ADDR_BYTE, PUSH_NEXT_ADDR_BYTE}, PUSH_WORD);
      chk16(OPND_WORD, {OPND_NEAR, OPND_FAR});
      @(posedge CLK);
      #1;
      BUS_RD = 1'b0;
      if (i % 2 == 1)
        chk16({8'h00, MIRROR_RDATA}, {8'h00, w.mirror_data});
    end
    print_verdict();
  end
endmodule
